// ---- mad_bitband.sv ----
// Bit-band alias translator.
// Masks the alias window base off the offset itself with MAD_BITB_MASK.
`timescale 1ns/100ps
`default_nettype none
module mad_bitband (
  // Alias offset and region base
  input wire logic [31:0] alias_off_i,
  input wire logic [31:0] region_base_i,
  // Translated word address and bit
  output logic [31:0] word_addr_o,
  output logic [4:0] bit_sel_o
);
  import mad_pkg::*;

  // Each alias word maps one bit: offset/128 picks the word, bits 6:2 the bit.
  logic [31:0] off;
  assign off = alias_off_i & MAD_BITB_MASK;
  assign word_addr_o = region_base_i + {8'h00, off[28:7], 2'h0};
  assign bit_sel_o = {off[6:5], off[4:2]};
endmodule : mad_bitband
`default_nettype wire

// ---- mad_decoder.sv ----
// Master address decoder for the application CPU and its channel DMA.
// Assumes one access at a time per request cycle and targets that accept a
// registered select one cycle after the request.
// Summary of operation
// R1 - Boot window and its alias reach the same 64K boot ROM.
// R2 - With 256KB flash, sectors I, H, G and F are absent.
// R3 - Zone one password low in sector N, zone two high in sector A.
// R4 - Flash check bits are a 64K window; channel DMA barred.
// R5 - Three OTP check-bit bytes exposed; channel DMA barred.
// R6 - ROM mirror reads return data and feed the CRC engine.
// R7 - RAM mirror reads return data and feed the CRC engine.
// R8 - RAM alias zone gives each local RAM bit its own address.
// R9 - Peripheral alias zone gives each register bit its own address.
// R10 - Secure local RAMs reachable by CPU only, not channel DMA.
// R11 - Shared RAMs map to the control side storage; both DMAs allowed.
// R12 - Inbound message RAM read-only to DMA; outbound writable.
// R13 - RAM check-bit windows decoded separately; channel DMA barred.
// R14 - Each GPIO port reachable through an APB and an AHB aperture.
// R15 - Device configuration also seen read-only by the control side.
// R16 - External bus window forwards everything; channel DMA allowed.
// R17 - Core-private registers on private bus, unreachable by DMA.
// R18 - Reserved or barred accesses end with bus error, no target touched.
// R19 - Masters issue byte addresses; the map is byte granular.
`timescale 1ns/100ps
`default_nettype none
module mad_decoder (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic small_flash_i,
  // Request
  input wire logic req_valid_i,
  input wire logic req_is_dma_i,
  input wire logic req_write_i,
  input wire logic [31:0] req_addr_i,
  // Decoded answer
  output logic sel_valid_o,
  output mad_pkg::mad_target_t sel_target_o,
  output logic [31:0] sel_addr_o,
  output logic [4:0] sel_bit_o,
  output logic sel_bit_mode_o,
  output logic sel_crc_feed_o,
  output logic sel_pwd_zone1_o,
  output logic sel_pwd_zone2_o,
  output logic [31:0] sel_ctrl_addr_o,
  output logic sel_ctrl_ro_o,
  output logic sel_bus_error_o
);
  import mad_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic valid;
    mad_target_t target;
    logic [31:0] addr;
    logic [4:0] bitsel;
    logic bit_mode;
    logic crc_feed;
    logic pwd1;
    logic pwd2;
    logic [31:0] ctrl_addr;
    logic ctrl_ro;
    logic err;
  } mad_state_t;

  mad_state_t st_q;
  mad_state_t st_d;

  logic flash_present;
  logic pwd1;
  logic pwd2;
  logic [31:0] bb_word;
  logic [4:0] bb_bit;
  logic [31:0] bb_base;
  logic [31:0] mirror_addr;
  logic mirror_flash;
  logic mirror_pwd1;
  logic mirror_pwd2;

  // ==========================================================================
  // Sub-decoders
  // ==========================================================================
  assign mirror_addr = req_addr_i & MAD_MIRROR_MASK;

  mad_flash_map u_flash (
    .addr_i(req_addr_i),
    .small_flash_i(small_flash_i),
    .present_o(flash_present),
    .pwd_zone1_o(pwd1),
    .pwd_zone2_o(pwd2)
  );

  mad_flash_map u_flash_mirror (
    .addr_i(mirror_addr),
    .small_flash_i(small_flash_i),
    .present_o(mirror_flash),
    .pwd_zone1_o(mirror_pwd1),
    .pwd_zone2_o(mirror_pwd2)
  );

  assign bb_base = (req_addr_i[31:28] == 4'h2) ? MAD_RAM_BASE : MAD_PERI_BASE;

  mad_bitband u_bitband (
    .alias_off_i(req_addr_i),
    .region_base_i(bb_base),
    .word_addr_o(bb_word),
    .bit_sel_o(bb_bit)
  );

  function automatic logic mad_apb_gap(input logic [31:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < MAD_RSV_N; i++) begin
      if (mad_in(a, MAD_RSV_LO[i], MAD_RSV_HI[i])) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : mad_apb_gap

  // ==========================================================================
  // Decode
  // ==========================================================================
  // The whole map is decoded on byte addresses, so no alignment check. [R19]
  always_comb begin
    st_d = '0;
    st_d.valid = req_valid_i;
    st_d.addr = req_addr_i;
    if (mad_in(req_addr_i, MAD_BOOT_LO, MAD_BOOT_LO + MAD_BOOT_SIZE - 32'h1) ||
        mad_in(req_addr_i, MAD_BOOT_ALIAS, MAD_BOOT_ALIAS + MAD_BOOT_SIZE - 32'h1)) begin
      st_d.target = MAD_TGT_BOOT_ROM;
      st_d.addr = {16'h0000, req_addr_i[15:0]}; // [R1]
    end else if (flash_present) begin
      st_d.target = MAD_TGT_FLASH; // [R2]
      st_d.pwd1 = pwd1; // [R3]
      st_d.pwd2 = pwd2; // [R3]
    end else if (mad_in(req_addr_i, MAD_FECC_LO, MAD_FECC_HI)) begin
      st_d.target = MAD_TGT_FLASH_ECC;
      st_d.err = req_is_dma_i; // [R4]
    end else if (mad_in(req_addr_i, MAD_OTP_LO, MAD_OTP_HI)) begin
      st_d.target = MAD_TGT_OTP;
      st_d.err = req_is_dma_i;
    end else if (mad_in(req_addr_i, MAD_OECC_LO, MAD_OECC_HI)) begin
      st_d.target = MAD_TGT_OTP_ECC;
      st_d.err = req_is_dma_i; // [R5]
    end else if (mad_in(req_addr_i, MAD_RMIR_LO, MAD_RMIR_HI)) begin
      // Mirror hits only if the folded address lands on a real ROM, flash, OTP or check-bit byte.
      st_d.target = MAD_TGT_ROM_MIRR;
      st_d.addr = mirror_addr;
      st_d.pwd1 = mirror_pwd1;
      st_d.pwd2 = mirror_pwd2;
      // Each store is listed on its own so that reserved gaps and absent sectors stay refused.
      st_d.err = req_is_dma_i || !(mirror_flash ||
                 mad_in(mirror_addr, MAD_BOOT_LO, MAD_BOOT_LO + MAD_BOOT_SIZE - 32'h1) ||
                 mad_in(mirror_addr, MAD_BOOT_ALIAS, MAD_BOOT_ALIAS + MAD_BOOT_SIZE - 32'h1) ||
                 mad_in(mirror_addr, MAD_FECC_LO, MAD_FECC_HI) ||
                 mad_in(mirror_addr, MAD_OTP_LO, MAD_OTP_HI) ||
                 mad_in(mirror_addr, MAD_OECC_LO, MAD_OECC_HI)); // [R18]
      st_d.crc_feed = !req_write_i && !st_d.err; // [R6]
    end else if (mad_in(req_addr_i, MAD_SEC_LO, MAD_SEC_HI)) begin
      st_d.target = MAD_TGT_SEC_RAM;
      st_d.err = req_is_dma_i; // [R10]
    end else if (mad_in(req_addr_i, MAD_SEC_HI + 32'h1, MAD_PAR_HI)) begin
      st_d.target = MAD_TGT_PAR_RAM;
    end else if (mad_in(req_addr_i, MAD_SHR_LO, MAD_SHR_HI)) begin
      st_d.target = MAD_TGT_SHR_RAM;
      // Control side sees the shared blocks in 16-bit words. [R11]
      st_d.ctrl_addr = MAD_CTRL_SHR_BASE + {1'b0, req_addr_i[31:1] - MAD_SHR_LO[31:1]};
    end else if (mad_in(req_addr_i, MAD_IN_MSG_LO, MAD_OUT_MSG_LO - 32'h1)) begin
      st_d.target = MAD_TGT_IN_MSG;
      st_d.err = req_is_dma_i && req_write_i; // [R12]
    end else if (mad_in(req_addr_i, MAD_OUT_MSG_LO, MAD_OUT_MSG_HI)) begin
      st_d.target = MAD_TGT_OUT_MSG;
      st_d.ctrl_ro = 1'b1; // [R12]
    end else if (mad_in(req_addr_i, MAD_CHK_LO, MAD_CHK_HI) ||
                 mad_in(req_addr_i, MAD_MCHK_LO, MAD_MCHK_HI)) begin
      st_d.target = MAD_TGT_RAM_CHK;
      st_d.err = req_is_dma_i; // [R13]
    end else if (mad_in(req_addr_i, MAD_RBB_LO, MAD_RBB_HI)) begin
      st_d.target = MAD_TGT_RAM_BITB;
      st_d.addr = bb_word; // [R8]
      st_d.bitsel = bb_bit;
      st_d.bit_mode = 1'b1;
      st_d.err = req_is_dma_i && (bb_word <= MAD_SEC_HI);
    end else if (mad_in(req_addr_i, MAD_RMIRR_LO, MAD_RMIRR_HI)) begin
      st_d.target = MAD_TGT_RAM_MIRR;
      st_d.addr = MAD_RAM_BASE | mirror_addr;
      st_d.err = req_is_dma_i;
      st_d.crc_feed = !req_write_i && !req_is_dma_i; // [R7]
    end else if (mad_in(req_addr_i, MAD_APB_LO, MAD_APB_HI) && !mad_apb_gap(req_addr_i)) begin
      st_d.target = MAD_TGT_APB_PERI; // [R14]
      st_d.err = req_is_dma_i && mad_in(req_addr_i, 32'h4002_0000, 32'h4002_1fff);
    end else if (mad_in(req_addr_i, MAD_ENET_LO, MAD_ENET_LO + 32'h0fff) ||
                 mad_in(req_addr_i, MAD_USB_LO, MAD_USB_LO + 32'h0fff)) begin
      st_d.target = MAD_TGT_APB_PERI;
    end else if (mad_in(req_addr_i, MAD_GPIOA_AHB, MAD_AHB_GPIO_HI)) begin
      st_d.target = MAD_TGT_AHB_GPIO; // [R14]
    end else if (mad_in(req_addr_i, MAD_SYS_LO, MAD_SYS_HI)) begin
      st_d.target = MAD_TGT_SYS_PERI;
      st_d.err = req_is_dma_i;
      if (mad_in(req_addr_i, MAD_DEVCFG_LO, MAD_DEVCFG_HI)) begin
        st_d.ctrl_addr = MAD_CTRL_DEVCFG + {1'b0, req_addr_i[31:1] - MAD_DEVCFG_LO[31:1]};
        st_d.ctrl_ro = 1'b1; // [R15]
      end
    end else if (mad_in(req_addr_i, MAD_PBB_LO, MAD_PBB_HI)) begin
      st_d.target = MAD_TGT_PERI_BITB;
      st_d.addr = bb_word; // [R9]
      st_d.bitsel = bb_bit;
      st_d.bit_mode = 1'b1;
    end else if (mad_in(req_addr_i, MAD_ADC1_LO, MAD_ADC1_LO + MAD_ADC_SIZE - 32'h1) ||
                 mad_in(req_addr_i, MAD_ADC2_LO, MAD_ADC2_LO + MAD_ADC_SIZE - 32'h1)) begin
      st_d.target = MAD_TGT_ANALOG;
    end else if (mad_in(req_addr_i, MAD_EXT_LO, MAD_EXT_HI)) begin
      st_d.target = MAD_TGT_EXT_BUS; // [R16]
    end else if (req_addr_i >= MAD_PRIV_LO) begin
      st_d.target = MAD_TGT_PRIVATE;
      st_d.err = req_is_dma_i; // [R17]
    end else begin
      st_d.err = 1'b1; // [R18]
    end
    // A refused access selects no target at all. [R18]
    if (st_d.err) begin
      st_d.target = MAD_TGT_NONE;
      st_d.crc_feed = 1'b0;
      st_d.bit_mode = 1'b0;
      st_d.ctrl_ro = 1'b0;
    end
    if (!req_valid_i) begin
      st_d = '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign sel_valid_o = st_q.valid;
  assign sel_target_o = st_q.target;
  assign sel_addr_o = st_q.addr;
  assign sel_bit_o = st_q.bitsel;
  assign sel_bit_mode_o = st_q.bit_mode;
  assign sel_crc_feed_o = st_q.crc_feed;
  assign sel_pwd_zone1_o = st_q.pwd1;
  assign sel_pwd_zone2_o = st_q.pwd2;
  assign sel_ctrl_addr_o = st_q.ctrl_addr;
  assign sel_ctrl_ro_o = st_q.ctrl_ro;
  assign sel_bus_error_o = st_q.err;

  // ==========================================================================
  // Checks
  // ==========================================================================
  AST_BOOT_ALIAS: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    req_valid_i && req_addr_i[31:16] == 16'h0100 |=> sel_target_o == MAD_TGT_BOOT_ROM && sel_addr_o[31:16] == 16'h0)
    else $error("Boot alias not routed to boot ROM.");
  AST_SMALL_FLASH: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    req_valid_i && small_flash_i && req_addr_i[31:16] == 16'h0023 |=> sel_bus_error_o)
    else $error("Absent flash sector was mapped.");
  AST_PWD2: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    req_valid_i && req_addr_i == 32'h0027_fff0 |=> sel_pwd_zone2_o && !sel_pwd_zone1_o)
    else $error("Zone two password marker wrong.");
  AST_FECC_DMA: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    req_valid_i && req_is_dma_i && req_addr_i[31:16] == 16'h0060 |=> sel_bus_error_o)
    else $error("DMA reached flash check bits.");
  AST_OECC_DMA: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    req_valid_i && req_is_dma_i && req_addr_i == 32'h0070_0102 |=> sel_bus_error_o)
    else $error("DMA reached OTP check bits.");
  AST_CRC_FEED: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    req_valid_i && !req_is_dma_i && !req_write_i && req_addr_i[31:26] == 6'h09 |=> sel_crc_feed_o)
    else $error("RAM mirror read did not feed the CRC.");
  AST_SEC_RAM: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    req_valid_i && req_addr_i[31:14] == 18'h08000 |=> sel_bus_error_o == $past(req_is_dma_i))
    else $error("Secure RAM access rule broken.");
  AST_IN_MSG: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    req_valid_i && req_is_dma_i && req_write_i && req_addr_i[31:11] == 21'h400fe |=> sel_bus_error_o)
    else $error("DMA write to inbound message RAM accepted.");
  AST_ERR_NOTGT: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    sel_bus_error_o |-> sel_target_o == MAD_TGT_NONE && !sel_crc_feed_o)
    else $error("Bus error with a target selected.");
  AST_PRIV_DMA: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    req_valid_i && req_is_dma_i && req_addr_i[31:28] == 4'he |=> sel_bus_error_o)
    else $error("DMA reached private bus.");
  AST_ROM_MIRR: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    req_valid_i && !req_is_dma_i && !req_write_i && req_addr_i[31:16] == 16'h0400
    |=> sel_crc_feed_o && sel_target_o == MAD_TGT_ROM_MIRR)
    else $error("ROM mirror read did not feed the CRC.");
  AST_SHR_CTRL: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    req_valid_i && req_addr_i[31:13] == 19'h10005 |=> sel_ctrl_addr_o[31:12] == 20'h0000d)
    else $error("Shared RAM control address wrong.");
  AST_CHK_DMA: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    req_valid_i && req_is_dma_i && req_addr_i[31:17] == 15'h1004 |=> sel_bus_error_o)
    else $error("DMA reached RAM check bits.");
  AST_EXT_BUS: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
    req_valid_i && req_addr_i[31:28] == 4'hd |=> sel_target_o == MAD_TGT_EXT_BUS)
    else $error("External window not forwarded.");
  COV_EXT: cover property (@(posedge clk_i) disable iff (rst_i) sel_target_o == MAD_TGT_EXT_BUS);
  COV_BITB: cover property (@(posedge clk_i) disable iff (rst_i) sel_bit_mode_o);
  COV_ROM_CRC: cover property (@(posedge clk_i) disable iff (rst_i)
    sel_crc_feed_o && sel_target_o == MAD_TGT_ROM_MIRR);
  COV_ERR: cover property (@(posedge clk_i) disable iff (rst_i) sel_bus_error_o);
endmodule : mad_decoder
`default_nettype wire

// ---- mad_flash_map.sv ----
// Flash sector decoder with size option and password markers.
// Assumes a static size strap.
`timescale 1ns/100ps
`default_nettype none
module mad_flash_map (
  // Request
  input wire logic [31:0] addr_i,
  input wire logic small_flash_i,
  // Result
  output logic present_o,
  output logic pwd_zone1_o,
  output logic pwd_zone2_o
);
  import mad_pkg::*;

  logic in_flash;
  logic in_gap;
  assign in_flash = mad_in(addr_i, MAD_FLASH_LO, MAD_FLASH_HI);
  assign in_gap = mad_in(addr_i, MAD_FLASH_GAP_LO, MAD_FLASH_GAP_HI);
  assign present_o = in_flash && !(small_flash_i && in_gap);
  assign pwd_zone1_o = mad_in(addr_i, MAD_PWD1_SECTOR, MAD_PWD1_SECTOR + MAD_PWD_BYTES - 32'h1);
  assign pwd_zone2_o = mad_in(addr_i, MAD_PWD2_SECTOR + MAD_SECTOR16_SIZE - MAD_PWD_BYTES,
                              MAD_PWD2_SECTOR + MAD_SECTOR16_SIZE - 32'h1);
endmodule : mad_flash_map
`default_nettype wire

// ---- mad_master_model.sv ----
// Bus master model that presents the bench's commands to the address decoder.
// Assumes commands change just after a rising edge of clk_i.
`timescale 1ns/100ps
`default_nettype none
module mad_master_model (
  // Clock
  input wire logic clk_i,
  // Command from the bench
  input wire logic cmd_valid_i,
  input wire logic cmd_dma_i,
  input wire logic cmd_write_i,
  input wire logic [31:0] cmd_addr_i,
  // Request to the decoder
  output logic req_valid_o,
  output logic req_is_dma_o,
  output logic req_write_o,
  output logic [31:0] req_addr_o
);
  logic [33:0] last_q = '0;
  always @(posedge clk_i) begin
    if (cmd_valid_i) last_q <= {cmd_dma_i, cmd_write_i, cmd_addr_i};
  end
  // An idle bus shows the inverse of the last request, so stale values never pass.
  assign req_valid_o = cmd_valid_i;
  assign req_is_dma_o = cmd_valid_i ? cmd_dma_i : ~last_q[33];
  assign req_write_o = cmd_valid_i ? cmd_write_i : ~last_q[32];
  assign req_addr_o = cmd_valid_i ? cmd_addr_i : ~last_q[31:0];
endmodule : mad_master_model
`default_nettype wire

// ---- mad_pkg.sv ----
// Package for the application-side master address decoder.
// Holds the decode map, target encodings and shared helper functions.
// Assumes 32-bit byte addresses from both bus masters.
package mad_pkg;

  // ==========================================================================
  // Target identifiers
  // ==========================================================================
  typedef enum logic [4:0] {
    MAD_TGT_NONE      = 5'h00,
    MAD_TGT_BOOT_ROM  = 5'h01,
    MAD_TGT_FLASH     = 5'h02,
    MAD_TGT_FLASH_ECC = 5'h03,
    MAD_TGT_OTP       = 5'h04,
    MAD_TGT_OTP_ECC   = 5'h05,
    MAD_TGT_ROM_MIRR  = 5'h06,
    MAD_TGT_SEC_RAM   = 5'h07,
    MAD_TGT_PAR_RAM   = 5'h08,
    MAD_TGT_SHR_RAM   = 5'h09,
    MAD_TGT_IN_MSG    = 5'h0a,
    MAD_TGT_OUT_MSG   = 5'h0b,
    MAD_TGT_RAM_CHK   = 5'h0c,
    MAD_TGT_RAM_BITB  = 5'h0d,
    MAD_TGT_RAM_MIRR  = 5'h0e,
    MAD_TGT_APB_PERI  = 5'h0f,
    MAD_TGT_AHB_GPIO  = 5'h10,
    MAD_TGT_SYS_PERI  = 5'h11,
    MAD_TGT_PERI_BITB = 5'h12,
    MAD_TGT_ANALOG    = 5'h13,
    MAD_TGT_EXT_BUS   = 5'h14,
    MAD_TGT_PRIVATE   = 5'h15
  } mad_target_t;

  // ==========================================================================
  // Address map
  // ==========================================================================
  localparam logic [31:0] MAD_BOOT_LO = 32'h0000_0000;
  localparam logic [31:0] MAD_BOOT_ALIAS = 32'h0100_0000;
  localparam logic [31:0] MAD_BOOT_SIZE = 32'h0001_0000;
  localparam logic [31:0] MAD_FLASH_LO = 32'h0020_0000;
  localparam logic [31:0] MAD_FLASH_HI = 32'h0027_ffff;
  localparam logic [31:0] MAD_FLASH_GAP_LO = 32'h0022_0000;
  localparam logic [31:0] MAD_FLASH_GAP_HI = 32'h0025_ffff;
  localparam logic [31:0] MAD_PWD1_SECTOR = 32'h0020_0000;
  localparam logic [31:0] MAD_PWD2_SECTOR = 32'h0027_c000;
  localparam logic [31:0] MAD_SECTOR16_SIZE = 32'h0000_4000;
  localparam logic [31:0] MAD_PWD_BYTES = 32'h0000_0010;
  localparam logic [31:0] MAD_FECC_LO = 32'h0060_0000;
  localparam logic [31:0] MAD_FECC_HI = 32'h0060_ffff;
  localparam logic [31:0] MAD_OTP_LO = 32'h0068_0480;
  localparam logic [31:0] MAD_OTP_HI = 32'h0068_0817;
  localparam logic [31:0] MAD_OECC_LO = 32'h0070_0100;
  localparam logic [31:0] MAD_OECC_HI = 32'h0070_0102;
  localparam logic [31:0] MAD_RMIR_LO = 32'h0400_0000;
  localparam logic [31:0] MAD_RMIR_HI = 32'h07ff_ffff;
  localparam logic [31:0] MAD_SEC_LO = 32'h2000_0000;
  localparam logic [31:0] MAD_SEC_HI = 32'h2000_3fff;
  localparam logic [31:0] MAD_PAR_HI = 32'h2000_7fff;
  localparam logic [31:0] MAD_SHR_LO = 32'h2000_8000;
  localparam logic [31:0] MAD_SHR_HI = 32'h2001_7fff;
  localparam logic [31:0] MAD_CTRL_SHR_BASE = 32'h0000_c000;
  localparam logic [31:0] MAD_IN_MSG_LO = 32'h2007_f000;
  localparam logic [31:0] MAD_OUT_MSG_LO = 32'h2007_f800;
  localparam logic [31:0] MAD_OUT_MSG_HI = 32'h2007_ffff;
  localparam logic [31:0] MAD_CHK_LO = 32'h2008_0000;
  localparam logic [31:0] MAD_CHK_HI = 32'h2009_7fff;
  localparam logic [31:0] MAD_MCHK_LO = 32'h200f_f000;
  localparam logic [31:0] MAD_MCHK_HI = 32'h200f_ffff;
  localparam logic [31:0] MAD_RBB_LO = 32'h2200_0000;
  localparam logic [31:0] MAD_RBB_HI = 32'h23ff_ffff;
  localparam logic [31:0] MAD_RMIRR_LO = 32'h2400_0000;
  localparam logic [31:0] MAD_RMIRR_HI = 32'h27ff_ffff;
  localparam logic [31:0] MAD_APB_LO = 32'h4000_0000;
  localparam logic [31:0] MAD_APB_HI = 32'h4004_7fff;
  localparam logic [31:0] MAD_GPIOA_APB = 32'h4000_4000;
  localparam logic [31:0] MAD_GPIOA_AHB = 32'h4005_8000;
  localparam logic [31:0] MAD_AHB_GPIO_HI = 32'h4006_0fff;
  localparam logic [31:0] MAD_ENET_LO = 32'h4004_8000;
  localparam logic [31:0] MAD_USB_LO = 32'h4005_0000;
  localparam logic [31:0] MAD_SYS_LO = 32'h4007_0000;
  localparam logic [31:0] MAD_SYS_HI = 32'h400f_ffff;
  localparam logic [31:0] MAD_DEVCFG_LO = 32'h400f_b900;
  localparam logic [31:0] MAD_DEVCFG_HI = 32'h400f_b93f;
  localparam logic [31:0] MAD_CTRL_DEVCFG = 32'h0000_0880;
  localparam logic [31:0] MAD_PBB_LO = 32'h4200_0000;
  localparam logic [31:0] MAD_PBB_HI = 32'h43ff_ffff;
  localparam logic [31:0] MAD_ADC1_LO = 32'h5000_1600;
  localparam logic [31:0] MAD_ADC2_LO = 32'h5000_1680;
  localparam logic [31:0] MAD_ADC_SIZE = 32'h0000_0020;
  localparam logic [31:0] MAD_EXT_LO = 32'h6000_0000;
  localparam logic [31:0] MAD_EXT_HI = 32'hdfff_ffff;
  localparam logic [31:0] MAD_PRIV_LO = 32'he000_0000;
  localparam logic [31:0] MAD_CORE_INTERRUPT_CONTROLLER_LO = 32'he000_e100;
  localparam logic [31:0] MAD_CORE_INTERRUPT_CONTROLLER_HI = 32'he000_e4ef;
  localparam logic [31:0] MAD_MIRROR_MASK = 32'h03ff_ffff;
  localparam logic [31:0] MAD_RAM_BASE = 32'h2000_0000;
  localparam logic [31:0] MAD_PERI_BASE = 32'h4000_0000;
  localparam logic [31:0] MAD_BITB_MASK = 32'h01ff_ffff;

  // APB peripheral gaps, a handful of checked sub-windows.
  localparam int MAD_RSV_N = 8;
  localparam logic [31:0] MAD_RSV_LO [MAD_RSV_N] = '{32'h4000_2000, 32'h4001_1000,
    32'h4002_2000, 32'h4002_8000, 32'h4003_4000, 32'h4003_e000, 32'h4004_9000, 32'h4005_1000};
  localparam logic [31:0] MAD_RSV_HI [MAD_RSV_N] = '{32'h4000_3fff, 32'h4001_ffff,
    32'h4002_3fff, 32'h4002_ffff, 32'h4003_cfff, 32'h4004_7fff, 32'h4004_ffff, 32'h4005_7fff};

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic mad_in(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : mad_in

endpackage : mad_pkg

// ---- tb_top.sv ----
// Self-checking bench for the master address decoder.
// Assumes the decoder answers every request exactly one cycle later.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mad_pkg::*;
  logic clk_i = 0, rst_i = 1, sf = 0, cv = 0, cd = 0, cw = 0;
  logic [31:0] ca = 0;
  logic rv, rd, rw;
  logic [31:0] ra;
  logic sel_valid_o, sel_bit_mode_o, sel_crc_feed_o, z1, z2, ro, err;
  mad_target_t tgt;
  logic [31:0] sa, cadr;
  logic [4:0] sb;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  mad_master_model PM (.clk_i(clk_i), .cmd_valid_i(cv), .cmd_dma_i(cd), .cmd_write_i(cw),
    .cmd_addr_i(ca), .req_valid_o(rv), .req_is_dma_o(rd), .req_write_o(rw), .req_addr_o(ra));
  mad_decoder DUT (.clk_i(clk_i), .rst_i(rst_i), .small_flash_i(sf), .req_valid_i(rv),
    .req_is_dma_i(rd), .req_write_i(rw), .req_addr_i(ra), .sel_valid_o(sel_valid_o),
    .sel_target_o(tgt), .sel_addr_o(sa), .sel_bit_o(sb), .sel_bit_mode_o(sel_bit_mode_o),
    .sel_crc_feed_o(sel_crc_feed_o), .sel_pwd_zone1_o(z1), .sel_pwd_zone2_o(z2),
    .sel_ctrl_addr_o(cadr), .sel_ctrl_ro_o(ro), .sel_bus_error_o(err));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // ====================
  // Helpers
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (e !== g) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chkb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask : chkb
  // Outputs stand until the next edge, so callers may check more fields afterwards.
  task automatic acc(input logic d, input logic w, input logic [31:0] a, input mad_target_t t,
      input logic [31:0] pa, input logic ck);
    @(posedge clk_i);
    cv <= 1'b1;
    cd <= d;
    cw <= w;
    ca <= a;
    @(posedge clk_i);
    cv <= 1'b0;
    #1;
    chkb("valid", 1'b1, sel_valid_o);
    chk("target", {27'h0, t}, {27'h0, tgt});
    chkb("error", t == MAD_TGT_NONE, err);
    if (ck) chk("addr", pa, sa);
  endtask : acc
  task automatic bad(input logic d, input logic w, input logic [31:0] a);
    acc(d, w, a, MAD_TGT_NONE, 32'h0, 1'b0);
  endtask : bad
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // ====================
  // Scenarios
  task automatic t_flash();
    acc(0, 0, 32'h0100_0010, MAD_TGT_BOOT_ROM, 32'h10, 1);
    acc(0, 0, 32'h0000_fffc, MAD_TGT_BOOT_ROM, 32'hfffc, 1);
    acc(0, 0, 32'h0022_0000, MAD_TGT_FLASH, 32'h0022_0000, 1);
    sf <= 1'b1;
    bad(0, 0, 32'h0025_fffc);
    bad(0, 0, 32'h0023_0000);
    bad(0, 0, 32'h0422_0000);
    acc(0, 0, 32'h0026_0000, MAD_TGT_FLASH, 32'h0026_0000, 1);
    sf <= 1'b0;
    acc(0, 0, 32'h0020_000c, MAD_TGT_FLASH, 32'h0020_000c, 1);
    chkb("zone1", 1'b1, z1);
    acc(0, 0, 32'h0027_fff0, MAD_TGT_FLASH, 32'h0027_fff0, 1);
    chkb("zone2", 1'b1, z2);
    chkb("zone1", 1'b0, z1);
    acc(0, 0, 32'h0060_ffff, MAD_TGT_FLASH_ECC, 32'h0060_ffff, 1);
    bad(1, 0, 32'h0060_0000);
    acc(0, 0, 32'h0070_0102, MAD_TGT_OTP_ECC, 32'h0070_0102, 1);
    bad(1, 0, 32'h0070_0100);
    bad(1, 1, 32'h0070_0102);
    bad(0, 0, 32'h0070_0103);
    bad(0, 1, 32'h0001_0000);
    $display("flash map done");
  endtask : t_flash
  task automatic t_ram();
    acc(0, 0, 32'h0400_0010, MAD_TGT_ROM_MIRR, 32'h0, 0);
    chkb("crc", 1'b1, sel_crc_feed_o);
    bad(0, 0, 32'h0401_0000);
    acc(0, 0, 32'h27ff_fffc, MAD_TGT_RAM_MIRR, 32'h0, 0);
    chkb("crc", 1'b1, sel_crc_feed_o);
    acc(0, 0, 32'h2200_0084, MAD_TGT_RAM_BITB, 32'h2000_0004, 1);
    chk("bit", 32'h1, {27'h0, sb});
    acc(1, 1, 32'h4200_00fc, MAD_TGT_PERI_BITB, 32'h4000_0004, 1);
    chk("bit", 32'h1f, {27'h0, sb});
    chkb("bitmode", 1'b1, sel_bit_mode_o);
    acc(0, 1, 32'h2000_3ffc, MAD_TGT_SEC_RAM, 32'h2000_3ffc, 1);
    bad(1, 0, 32'h2000_0000);
    acc(1, 1, 32'h2000_a000, MAD_TGT_SHR_RAM, 32'h2000_a000, 1);
    chk("ctrl", 32'hd000, cadr);
    acc(1, 0, 32'h2007_f000, MAD_TGT_IN_MSG, 32'h2007_f000, 1);
    bad(1, 1, 32'h2007_f7fc);
    acc(1, 1, 32'h2007_f800, MAD_TGT_OUT_MSG, 32'h2007_f800, 1);
    chkb("ctrl_ro", 1'b1, ro);
    acc(0, 0, 32'h2008_4000, MAD_TGT_RAM_CHK, 32'h2008_4000, 1);
    bad(1, 0, 32'h2008_4000);
    bad(0, 0, 32'h2001_8000);
    $display("ram map done");
  endtask : t_ram
  task automatic t_peri();
    acc(1, 0, 32'h4000_4000, MAD_TGT_APB_PERI, 32'h4000_4000, 1);
    acc(1, 0, 32'h4005_8000, MAD_TGT_AHB_GPIO, 32'h4005_8000, 1);
    acc(0, 1, 32'h400f_b904, MAD_TGT_SYS_PERI, 32'h400f_b904, 1);
    chk("ctrl", 32'h882, cadr);
    chkb("ctrl_ro", 1'b1, ro);
    acc(1, 1, 32'hdfff_fffc, MAD_TGT_EXT_BUS, 32'hdfff_fffc, 1);
    acc(0, 0, 32'he000_e100, MAD_TGT_PRIVATE, 32'he000_e100, 1);
    bad(1, 0, 32'he000_e100);
    bad(0, 0, 32'h2800_0000);
    $display("peripheral map done");
  endtask : t_peri
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_flash();
    t_ram();
    t_peri();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
